/* verilog/plca_pkg.sv */
// constants and code tables for the twisted-pair line coding and auto-negotiation block
package plca_pkg;
    // ************************************************************
    // clocking and timing
    // ************************************************************
    localparam int MCLK_HZ       = 20_000_000;
    localparam int MDIX_SLOT_MS  = 62;
    localparam int MDIX_SLOT_CYC = MDIX_SLOT_MS * (MCLK_HZ / 1000);
    localparam int PD_WAIT_MS    = 50;
    localparam int PD_WAIT_CYC   = PD_WAIT_MS * (MCLK_HZ / 1000);
    localparam int TX_DIV        = 4;
    localparam int RX_OS         = 4;
    localparam int MAN_BIT       = 8;

    // ************************************************************
    // scrambler
    // ************************************************************
    localparam int          LFSR_W     = 11;
    localparam int          TAP_HI     = 10;
    localparam int          TAP_LO     = 8;
    localparam logic [10:0] LFSR_SEED  = 11'h7FF;
    localparam logic [4:0]  LOCK_MATCH = 5'h1D;

    // ************************************************************
    // code groups
    // ************************************************************
    localparam logic [4:0] SYM_IDLE = 5'h1F;
    localparam logic [4:0] SYM_J    = 5'h18;
    localparam logic [4:0] SYM_K    = 5'h11;
    localparam logic [4:0] SYM_T    = 5'h0D;
    localparam logic [4:0] SYM_R    = 5'h07;

    // ability bits: 3=100 full, 2=100 half, 1=10 full, 0=10 half
    localparam int AB_100F = 3;
    localparam int AB_100H = 2;
    localparam int AB_10F  = 1;

    localparam logic [79:0] ENC_TAB = {
        5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
        5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};

    function automatic logic [4:0] plca_enc(input logic [3:0] nib);
        plca_enc = ENC_TAB[{nib, 2'h0} + {3'h0, nib} +: 5];
    endfunction

    // returns {valid, nibble}
    function automatic logic [4:0] plca_dec(input logic [4:0] sym);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (ENC_TAB[i*5 +: 5] == sym) begin
                r = {1'b1, 4'(i)};
            end
        end
        plca_dec = r;
    endfunction
endpackage

/* verilog/plca_fifo.sv */
// synchronous valid/ready fifo between the mac nibble port and the transmit coder
`timescale 1ns/100ps
module plca_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* verilog/plca_core.sv */
// line coding, pair assignment and link mode resolution for one twisted-pair port
//
// Summary of operation
// RULE_01 - MAC nibbles are serialised into one line bit per symbol-rate tick.
// RULE_02 - transmit data and control pass through 4B/5B coding, then the scrambler.
// RULE_03 - scrambled bits are converted from NRZ to NRZI before the line stage.
// RULE_04 - receive bit clock recovered from NRZI transitions; it converts back to NRZ.
// RULE_05 - receive bits descrambled, 5B decoded to 4B, delivered as nibbles to MAC.
// RULE_06 - scrambling in 100 mode only, 11-bit LFSR with 2047-bit period.
// RULE_07 - descrambler applies the same sequence the transmitting scrambler used.
// RULE_08 - 10 Mb/s Manchester input split into recovered clock and NRZ data.
// RULE_09 - 10 Mb/s receive clock keeps running through idle gaps.
// RULE_10 - two crossover schemes, vendor-style and IEEE; vendor-style is default.
// RULE_11 - crossover detects partner transmit pair and swaps own pair assignment.
// RULE_12 - crossover can be disabled by port control or management setting.
// RULE_13 - both sides advertise abilities and compare received with own.
// RULE_14 - resolve highest common: 100 full, 100 half, 10 full, 10 half.
// RULE_15 - without negotiation, mode chosen by sensing fixed receive signalling.
// RULE_16 - all timing derived from the single 25 MHz-class reference clock; here mclk is set to 20 MHz (MCLK_HZ).
// RULE_17 - polynomial x^11+x^9+1; descrambler self-synchronises on idle.
// RULE_18 - idle between frames; frames delimited by start and end code groups.
`timescale 1ns/100ps
module plca_core #(
    parameter int MDIX_SLOT = plca_pkg::MDIX_SLOT_CYC,
    parameter int PD_WAIT   = plca_pkg::PD_WAIT_CYC,
    parameter int TX_DIV    = plca_pkg::TX_DIV,
    parameter int RX_OS     = plca_pkg::RX_OS,
    parameter int MAN_BIT   = plca_pkg::MAN_BIT,
    parameter int FIFO_D    = 16
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [3:0] mac_txd,
    input  wire logic       mac_tx_last,
    input  wire logic       mac_tx_valid,
    output logic            mac_tx_ready,
    output logic [3:0]      mac_rxd,
    output logic            mac_rx_valid,
    output logic            mac_rx_err,
    input  wire logic       line_a_in,
    input  wire logic       line_b_in,
    output logic            line_a_out,
    output logic            line_b_out,
    output logic            rx10_clk,
    output logic            rx10_data,
    output logic            rx10_valid,
    output logic            rx10_carrier,
    input  wire logic       mdix_port_dis,
    input  wire logic       mdix_mgmt_dis,
    input  wire logic       mdix_ieee,
    output logic            mdix_state,
    input  wire logic       an_enable,
    input  wire logic       an_restart,
    input  wire logic [3:0] adv_local,
    input  wire logic [3:0] lp_ability,
    input  wire logic       lp_valid,
    input  wire logic       nlp_seen,
    output logic [3:0]      an_adv,
    output logic            an_done,
    output logic            speed_100,
    output logic            full_duplex,
    output logic            pd_used,
    output logic            descr_locked
);
    // ************************************************************
    // transmit fifo and symbol-rate tick
    // ************************************************************
    typedef enum logic [5:0] {
        TX_IDLE = 6'b000001, TX_J = 6'b000010, TX_K = 6'b000100,
        TX_DATA = 6'b001000, TX_T = 6'b010000, TX_R = 6'b100000
    } plca_tx_t;

    plca_tx_t    tx_q;
    logic        f_valid;
    logic        f_ready;
    logic [4:0]  f_data;
    logic [7:0]  div_q;
    logic        tick;
    logic [2:0]  bit_q;
    logic [4:0]  sym_q;
    logic [10:0] scr_q;
    logic        scr_fb;
    logic        tx_line_q;
    logic        sym_end;

    plca_fifo #(.WIDTH(5), .DEPTH(FIFO_D)) u_fifo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .in_valid  (mac_tx_valid),
        .in_ready  (mac_tx_ready),
        .in_data   ({mac_tx_last, mac_txd}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // bit rate is a division of mclk so no second clock source exists
    assign tick    = (div_q == 8'(TX_DIV - 1)); // RULE_16
    assign sym_end = tick && (bit_q == 3'h4);
    assign f_ready = sym_end && (tx_q == TX_K || tx_q == TX_DATA);
    assign scr_fb  = scr_q[plca_pkg::TAP_HI] ^ scr_q[plca_pkg::TAP_LO]; // RULE_17

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 8'h00;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
        end
    end

    // frame sequencer: J K data... T R, idle otherwise
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q  <= TX_IDLE;
            sym_q <= plca_pkg::SYM_IDLE;
            bit_q <= 3'h0;
        end else if (tick) begin
            if (bit_q != 3'h4) begin
                bit_q <= bit_q + 3'h1;
                sym_q <= {sym_q[3:0], 1'b0}; // RULE_01
            end else begin
                bit_q <= 3'h0;
                case (tx_q)
                    TX_IDLE: begin
                        if (f_valid) begin // RULE_18
                            tx_q  <= TX_J;
                            sym_q <= plca_pkg::SYM_J;
                        end else begin
                            sym_q <= plca_pkg::SYM_IDLE;
                        end
                    end
                    TX_J: begin
                        tx_q  <= TX_K;
                        sym_q <= plca_pkg::SYM_K;
                    end
                    TX_K, TX_DATA: begin
                        // a drained fifo mid-frame closes the frame rather than stalling the line
                        if (f_valid) begin
                            tx_q  <= f_data[4] ? TX_T : TX_DATA;
                            sym_q <= plca_pkg::plca_enc(f_data[3:0]); // RULE_02
                        end else begin
                            tx_q  <= TX_R;
                            sym_q <= plca_pkg::SYM_T;
                        end
                    end
                    TX_T: begin
                        tx_q  <= TX_R;
                        sym_q <= plca_pkg::SYM_T;
                    end
                    TX_R: begin
                        tx_q  <= TX_IDLE;
                        sym_q <= plca_pkg::SYM_R;
                    end
                    default: begin
                        tx_q  <= TX_IDLE;
                        sym_q <= plca_pkg::SYM_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // scrambler and nrzi encoder
    // ************************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scr_q     <= plca_pkg::LFSR_SEED;
            tx_line_q <= 1'b0;
        end else if (tick && speed_100) begin // RULE_06
            scr_q <= {scr_q[9:0], scr_fb}; // RULE_06
            if (sym_q[4] ^ scr_fb) begin // RULE_02
                tx_line_q <= ~tx_line_q; // RULE_03
            end
        end
    end

    // ************************************************************
    // receive pair selection and 100 Mb/s clock recovery
    // ************************************************************
    logic       mdix_q;
    logic       rx_in;
    logic       rx_prev_q;
    logic       rx_edge;
    logic [7:0] ph_q;
    logic       rx_tick;
    logic       lvl_q;
    logic       nrz;

    assign rx_in   = mdix_q ? line_a_in : line_b_in; // RULE_11
    assign rx_edge = rx_in ^ rx_prev_q;
    assign rx_tick = (ph_q == 8'(RX_OS / 2));
    assign nrz     = rx_in ^ lvl_q; // RULE_04

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_prev_q <= 1'b0;
            ph_q      <= 8'h00;
            lvl_q     <= 1'b0;
        end else begin
            rx_prev_q <= rx_in;
            // phase realigns on every transition, so the sample falls in the last cycle of each bit
            if (rx_edge) begin
                ph_q <= 8'h00; // RULE_04
            end else begin
                ph_q <= (ph_q == 8'(RX_OS - 1)) ? 8'h00 : ph_q + 8'h01;
            end
            if (rx_tick) begin
                lvl_q <= rx_in;
            end
        end
    end

    // ************************************************************
    // descrambler, alignment and 5B decode
    // ************************************************************
    logic [10:0] dsc_q;
    logic        dsc_fb;
    logic [4:0]  match_q;
    logic        lock_q;
    logic        plain;
    logic [9:0]  sh_q;
    logic        align_q;
    logic [2:0]  rcnt_q;
    logic [4:0]  dec;

    assign dsc_fb = dsc_q[plca_pkg::TAP_HI] ^ dsc_q[plca_pkg::TAP_LO];
    assign plain  = nrz ^ dsc_fb; // RULE_07
    assign dec    = plca_pkg::plca_dec({sh_q[3:0], plain});

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dsc_q   <= plca_pkg::LFSR_SEED;
            match_q <= 5'h00;
            lock_q  <= 1'b0;
        end else if (!speed_100) begin
            lock_q  <= 1'b0;
            match_q <= 5'h00;
        end else if (rx_tick) begin
            if (lock_q) begin
                dsc_q <= {dsc_q[9:0], dsc_fb}; // RULE_07
            end else begin
                // idle is all ones, so the inverted line bit is the key itself
                dsc_q   <= {dsc_q[9:0], ~nrz}; // RULE_17
                match_q <= (dsc_fb == ~nrz) ? match_q + 5'h01 : 5'h00;
                lock_q  <= (match_q == plca_pkg::LOCK_MATCH);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sh_q         <= 10'h000;
            align_q      <= 1'b0;
            rcnt_q       <= 3'h0;
            mac_rxd      <= 4'h0;
            mac_rx_valid <= 1'b0;
            mac_rx_err   <= 1'b0;
        end else begin
            mac_rx_valid <= 1'b0;
            mac_rx_err   <= 1'b0;
            if (rx_tick && lock_q) begin
                sh_q <= {sh_q[8:0], plain};
                if (!align_q) begin
                    if ({sh_q[8:0], plain} == {plca_pkg::SYM_J, plca_pkg::SYM_K}) begin
                        align_q <= 1'b1;
                        rcnt_q  <= 3'h0;
                    end
                end else if (rcnt_q == 3'h4) begin
                    rcnt_q <= 3'h0;
                    if ({sh_q[3:0], plain} == plca_pkg::SYM_T) begin
                        align_q <= 1'b0;
                    end else if (dec[4]) begin
                        mac_rxd      <= dec[3:0]; // RULE_05
                        mac_rx_valid <= 1'b1;
                    end else begin
                        mac_rx_err <= 1'b1;
                        align_q    <= 1'b0;
                    end
                end else begin
                    rcnt_q <= rcnt_q + 3'h1;
                end
            end
        end
    end

    // ************************************************************
    // 10 Mb/s manchester separation
    // ************************************************************
    logic [7:0] gap_q;
    logic [7:0] c10_q;
    logic       mid_edge;

    assign mid_edge = rx_edge && (gap_q >= 8'((MAN_BIT * 3) / 4));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q        <= 8'h00;
            c10_q        <= 8'h00;
            rx10_clk     <= 1'b0;
            rx10_data    <= 1'b0;
            rx10_valid   <= 1'b0;
            rx10_carrier <= 1'b0;
        end else begin
            rx10_valid <= 1'b0;
            if (rx_edge) begin
                gap_q <= mid_edge ? 8'h00 : gap_q;
            end else if (gap_q != 8'hFF) begin
                gap_q <= gap_q + 8'h01;
            end
            if (mid_edge && !speed_100) begin
                rx10_data  <= rx_in; // RULE_08
                rx10_valid <= 1'b1;
            end
            rx10_carrier <= !speed_100 && (gap_q < 8'(MAN_BIT * 2));
            // free running divider, only re-phased by data: never stops in idle
            if (mid_edge) begin
                c10_q    <= 8'h00;
                rx10_clk <= 1'b1; // RULE_08
            end else if (c10_q == 8'(MAN_BIT / 2 - 1)) begin
                c10_q    <= 8'h00;
                rx10_clk <= ~rx10_clk; // RULE_09
            end else begin
                c10_q <= c10_q + 8'h01;
            end
        end
    end

    // ************************************************************
    // automatic crossover
    // ************************************************************
    logic [23:0] slot_q;
    logic        slot_end;
    logic        act_q;

    assign slot_end = (slot_q == 24'(MDIX_SLOT - 1));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            slot_q <= 24'h000000;
            act_q  <= 1'b0;
            mdix_q <= 1'b0;
        end else begin
            slot_q <= slot_end ? 24'h000000 : slot_q + 24'h000001;
            // activity arriving in the clearing cycle survives into the next slot
            act_q  <= rx_edge || (act_q && !slot_end);
            if (mdix_port_dis || mdix_mgmt_dis) begin
                mdix_q <= 1'b0; // RULE_12
            end else if (slot_end && !act_q && !rx_edge) begin
                // vendor scheme hops every silent slot, IEEE hops on a random draw
                if (!mdix_ieee || scr_q[0]) begin // RULE_10
                    mdix_q <= ~mdix_q; // RULE_11
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            line_a_out <= 1'b0;
            line_b_out <= 1'b0;
        end else begin
            line_a_out <= mdix_q ? 1'b0 : (tx_line_q && speed_100); // RULE_11
            line_b_out <= mdix_q ? (tx_line_q && speed_100) : 1'b0;
        end
    end

    // ************************************************************
    // auto-negotiation and parallel detection
    // ************************************************************
    typedef enum logic [1:0] {AN_ADV = 2'b01, AN_DONE = 2'b10} plca_an_t;

    plca_an_t    an_q;
    logic [23:0] pdw_q;
    logic [3:0]  common;

    assign common = adv_local & lp_ability; // RULE_13

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            an_q        <= AN_ADV;
            pdw_q       <= 24'h000000;
            an_adv      <= 4'h0;
            speed_100   <= 1'b1;
            full_duplex <= 1'b0;
            pd_used     <= 1'b0;
        end else begin
            an_adv <= an_enable ? adv_local : 4'h0; // RULE_13
            case (an_q)
                AN_ADV: begin
                    pdw_q <= pdw_q + 24'h000001;
                    if (an_enable && lp_valid && common != 4'h0) begin
                        an_q        <= AN_DONE;
                        pd_used     <= 1'b0;
                        speed_100   <= common[plca_pkg::AB_100F] || common[plca_pkg::AB_100H]; // RULE_14
                        full_duplex <= common[plca_pkg::AB_100F] ||
                                       (!common[plca_pkg::AB_100H] && common[plca_pkg::AB_10F]);
                    end else if (pdw_q == 24'(PD_WAIT - 1) || !an_enable) begin
                        pdw_q <= 24'h000000;
                        if (lock_q) begin
                            an_q        <= AN_DONE; // RULE_15
                            speed_100   <= 1'b1;
                            full_duplex <= 1'b0;
                            pd_used     <= 1'b1;
                        end else if (nlp_seen || rx10_carrier) begin
                            an_q        <= AN_DONE; // RULE_15
                            speed_100   <= 1'b0;
                            full_duplex <= 1'b0;
                            pd_used     <= 1'b1;
                        end else begin
                            // alternate the listening speed so both signallings can be heard
                            speed_100 <= ~speed_100;
                        end
                    end
                end
                AN_DONE: begin
                    pdw_q <= 24'h000000;
                    if (an_restart || (slot_end && !act_q && !rx_edge)) begin
                        an_q <= AN_ADV;
                    end
                end
                default: an_q <= AN_ADV;
            endcase
        end
    end

    assign an_done      = (an_q == AN_DONE);
    assign mdix_state   = mdix_q;
    assign descr_locked = lock_q;

endmodule

/* dv/plca_core_assertions.sv */
// concurrent checks at the ports of plca_core
`timescale 1ns/100ps
module plca_chk (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic       mac_rx_valid,
    input wire logic       line_a_out,
    input wire logic       line_b_out,
    input wire logic       rx10_valid,
    input wire logic       rx10_carrier,
    input wire logic       mdix_port_dis,
    input wire logic       mdix_mgmt_dis,
    input wire logic       mdix_state,
    input wire logic       an_enable,
    input wire logic [3:0] an_adv,
    input wire logic       speed_100,
    input wire logic       full_duplex,
    input wire logic       pd_used
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // the line level lags mode and pair by one cycle, so a change there may cut a bit short
    sequence s_hold3;
        ($stable(line_a_out) || !$past(speed_100) || !$past(speed_100, 2) ||
            $past(mdix_state) != $past(mdix_state, 2))[*3];
    endsequence
    sequence s_quiet8; !mac_rx_valid[*8]; endsequence
    property p_bit_hold;
        $past(speed_100) && $past(speed_100, 2) && $past(mdix_state) == $past(mdix_state, 2) &&
            $changed(line_a_out) |=> s_hold3;
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("line bit too short");
    property p_rx_gap; mac_rx_valid |=> s_quiet8; endproperty
    a_rx_gap: assert property (p_rx_gap) else $error("nibbles too close");
    property p_no_tx10; !speed_100 && !$past(speed_100) |-> !line_a_out && !line_b_out; endproperty
    a_no_tx10: assert property (p_no_tx10) else $error("line driven at 10M");
    property p_rx10_off; speed_100 && $past(speed_100) |-> !rx10_valid && !rx10_carrier; endproperty
    a_rx10_off: assert property (p_rx10_off) else $error("10M receive at 100M");
    property p_mdix_off;
        (mdix_port_dis && $past(mdix_port_dis)) || (mdix_mgmt_dis && $past(mdix_mgmt_dis)) |-> !mdix_state;
    endproperty
    a_mdix_off: assert property (p_mdix_off) else $error("crossover not disabled");
    property p_idle_pair; !mdix_state && !$past(mdix_state) |-> !line_b_out; endproperty
    a_idle_pair: assert property (p_idle_pair) else $error("receive pair driven");
    property p_pd_half; pd_used |-> !full_duplex; endproperty
    a_pd_half: assert property (p_pd_half) else $error("detected mode full duplex");
    property p_adv_off; !an_enable && !$past(an_enable) |-> an_adv == 4'h0; endproperty
    a_adv_off: assert property (p_adv_off) else $error("advert while disabled");
endmodule
bind plca_core plca_chk u_chk (.mclk, .reset_n, .mac_rx_valid, .line_a_out, .line_b_out, .rx10_valid,
    .rx10_carrier, .mdix_port_dis, .mdix_mgmt_dis, .mdix_state, .an_enable, .an_adv, .speed_100,
    .full_duplex, .pd_used);

/* dv/plca_partner.sv */
// remote partner: scrambled idle on the line, nrzi coded, four cycles a bit
`timescale 1ns/100ps
module plca_partner (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic en,
    output logic      line
);
    logic [10:0] lfsr_q;
    logic [1:0]  ph_q;
    // line holds still while silent, so no false activity is seen
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lfsr_q <= 11'h7FF;
            ph_q   <= 2'h0;
            line   <= 1'b0;
        end else if (en) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h3) begin
                lfsr_q <= {lfsr_q[9:0], lfsr_q[10] ^ lfsr_q[8]};
                line   <= line ^ ~(lfsr_q[10] ^ lfsr_q[8]);
            end
        end
    end
endmodule

/* dv/test_plca_core.sv */
// self-checking bench for plca_core
`timescale 1ns/100ps
module test_plca_core;
    logic       mclk, reset_n, mac_tx_last, mac_tx_valid, mac_tx_ready, mac_rx_valid, mac_rx_err;
    logic       line_a_out, line_b_out, rx10_clk, rx10_data, rx10_valid, rx10_carrier, mdix_state;
    logic       mdix_port_dis, mdix_mgmt_dis, an_enable, an_restart, lp_valid, nlp_seen, an_done;
    logic       speed_100, full_duplex, pd_used, descr_locked, p_en, lb, p_line;
    logic [3:0] mac_txd, mac_rxd, adv_local, lp_ability, an_adv;
    int         errors, check_count;
    // {advertised, partner, {done, speed_100, full_duplex, pd_used}}
    localparam logic [11:0] AN_TAB [5] = '{12'hF4C, 12'hF2A, 12'hF18, 12'h3FA, 12'hF8E};
    plca_core #(.MDIX_SLOT(200), .PD_WAIT(500)) dut_u (.mclk, .reset_n, .mac_txd, .mac_tx_last,
        .mac_tx_valid, .mac_tx_ready, .mac_rxd, .mac_rx_valid, .mac_rx_err, .line_a_in(p_line),
        .line_b_in(lb ? line_a_out : p_line), .line_a_out, .line_b_out, .rx10_clk, .rx10_data,
        .rx10_valid, .rx10_carrier, .mdix_port_dis, .mdix_mgmt_dis, .mdix_ieee(1'b0), .mdix_state,
        .an_enable, .an_restart, .adv_local, .lp_ability, .lp_valid, .nlp_seen, .an_adv, .an_done,
        .speed_100, .full_duplex, .pd_used, .descr_locked);
    plca_partner partner_u (.mclk, .reset_n, .en(p_en), .line(p_line));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic restart_wait(input int n);
        an_restart = 1'b1;
        @(negedge mclk);
        an_restart = 1'b0;
        repeat (2) @(negedge mclk);
        repeat (n) begin
            @(negedge mclk);
            if (an_done === 1'b1 || lp_ability !== 4'h0) break;
        end
    endtask
    task automatic t_pd10;
        logic b;
        restart_wait(1500);
        repeat (300) @(negedge mclk);
        b = rx10_clk;
        repeat (4) @(negedge mclk);
        chk({2'h0, rx10_clk ^ b, rx10_carrier}, 4'h2);
        chk({an_done, speed_100, full_duplex, pd_used}, 4'h9);
        chk({3'h0, mdix_state}, 4'h0);
        nlp_seen = 1'b0;
        mdix_port_dis = 1'b0;
    endtask
    task automatic t_an;
        an_enable = 1'b1;
        p_en = 1'b1;
        foreach (AN_TAB[k]) begin
            adv_local = AN_TAB[k][11:8];
            lp_ability = AN_TAB[k][7:4];
            restart_wait(0);
            chk(an_adv, adv_local);
            lp_valid = 1'b1;
            @(negedge mclk);
            lp_valid = 1'b0;
            repeat (50) @(negedge mclk);
            chk({an_done, speed_100, full_duplex, pd_used}, AN_TAB[k][3:0]);
        end
    endtask
    task automatic t_loop;
        int n, full;
        full = 0;
        mdix_mgmt_dis = 1'b1;
        lb = 1'b1;
        for (n = 0; n < 5000 && descr_locked !== 1'b1; n++) @(negedge mclk);
        chk({3'h0, descr_locked}, 4'h1);
        fork
            begin
                int i;
                i = 0;
                while (i < 20) begin
                    mac_txd = i[3:0];
                    mac_tx_last = (i == 19);
                    mac_tx_valid = 1'b1;
                    if (mac_tx_ready !== 1'b1) full++;
                    else i++;
                    @(negedge mclk);
                end
                mac_tx_valid = 1'b0;
            end
            for (int j = 0; j < 20; j++) begin
                for (n = 0; n < 500 && mac_rx_valid !== 1'b1; n++) @(negedge mclk);
                chk(mac_rxd, j[3:0]);
                @(negedge mclk);
            end
        join
        chk({3'h0, full > 0}, 4'h1);
    endtask
    initial begin
        {reset_n, an_enable, an_restart, lp_valid, mdix_mgmt_dis, mac_tx_last, mac_tx_valid, p_en, lb} = '0;
        {nlp_seen, mdix_port_dis} = 2'h3;
        {adv_local, lp_ability, mac_txd} = 12'hF00;
        errors = 0;
        check_count = 0;
        repeat (16) @(negedge mclk);
        chk({speed_100, mac_tx_ready, mdix_state, an_done}, 4'hC);
        reset_n = 1'b1;
        t_pd10();
        t_an();
        t_loop();
        stop_test();
    end
    initial begin
        #3_000_000;
        errors++;
        stop_test();
    end
endmodule
